// file: rtl/swpsc_ctrl.sv
// Purpose: suspend/wake power state controller with Wishbone registers
// Assumes: 40 MHz clk_i, synchronous active high rst_i
// Notes: pins and bus power pass two flops; usb events are same domain
`timescale 1ns/10ps
`default_nettype none
`include "swpsc_defs.svh"
//Function
//RQ1: resume keeps context then sets ready
//RQ2: host selects level before suspend
//RQ3: resume or permitted wake returns normal
//RQ4: unconfigured suspend uses level 2 only
//RQ5: deconfigure resets level field to 10b
//RQ6: bus or pin reset gives unconfigured
//RQ7: level codes 00 to 11, default 10
//RQ8: level 0 wakes: resume, lan, link, pins
//RQ9: level 1 wakes: resume, energy, pins
//RQ10: level 2 wakes: resume or pins only
//RQ11: host reinitialises phy after level 2
//RQ12: level 3 keeps all clocks running
//RQ13: level 3 wakes: resume, pins, link, frames
//RQ14: lan bit set for lan and frames
//RQ15: lan events in level 3 drop frames
//RQ16: pin wake sets its own status flag
//RQ17: pending wake re-wakes right after suspend
//RQ18: link-up select readable for pin 7
//RQ19: host resume always accepted levels 0/1
//RQ20: no bus power forces unpowered state
//RQ21: configure and deconfigure move normal state
//RQ22: mask unpermitted wakes, hold permitted ones
module swpsc_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_reset_n_i,
  input wire logic usb_reset_i,
  input wire logic usb_suspend_i,
  input wire logic usb_resume_i,
  input wire logic usb_configured_i,
  input wire logic usb_deconfigured_i,
  input wire logic bus_power_detect_i,
  input wire logic lan_wake_i,
  input wire logic good_frame_i,
  input wire logic energy_detect_i,
  input wire logic link_up_i,
  input wire logic [`SWPSC_NPIN-1:0] pin_wake_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`SWPSC_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [2:0] power_state_o,
  output logic clocks_on_o,
  output logic phy_power_o,
  output logic remote_wake_o,
  output logic drop_frames_o,
  output logic ready_o
);
  // =========================================================
  // input synchronisers
  // =========================================================
  logic [`SWPSC_NPIN-1:0] pin_s;
  logic [2:0] misc_s;
  logic [2:0] misc_raw;
  logic rstn_s;
  logic vbus_s;
  assign misc_raw = {pin_reset_n_i, bus_power_detect_i, 1'b0};
  swpsc_sync #(.W(`SWPSC_NPIN)) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pin_wake_i),
    .q_o(pin_s)
  );
  swpsc_sync #(.W(3)) u_misc_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(misc_raw),
    .q_o(misc_s)
  );
  // reset pin reads low after rst_i too, so hold it off until seen high
  logic rstn_seen_r;
  logic rstn_seen_nxt;
  always_comb begin
    rstn_seen_nxt = rstn_seen_r | misc_s[2];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rstn_seen_r <= 1'b0;
    end else begin
      rstn_seen_r <= rstn_seen_nxt;
    end
  end
  assign rstn_s = misc_s[2] | ~rstn_seen_r;
  assign vbus_s = misc_s[1];
  // =========================================================
  // register state
  // =========================================================
  swpsc_pkg::swpsc_state_t state_r;
  swpsc_pkg::swpsc_state_t state_nxt;
  logic [1:0] mode_r;
  logic [1:0] mode_nxt;
  logic [1:0] level_r;
  logic [1:0] level_nxt;
  logic lwe_r;
  logic lwe_nxt;
  logic [1:0] wakeup_status_field_r;
  logic [1:0] wakeup_status_field_nxt;
  logic [`SWPSC_NPIN-1:0] pflag_r;
  logic [`SWPSC_NPIN-1:0] pflag_nxt;
  logic link_sel_r;
  logic link_sel_nxt;
  logic [`SWPSC_WFCS_W-1:0] wfcs_r;
  logic [`SWPSC_WFCS_W-1:0] wfcs_nxt;
  logic ready_r;
  logic ready_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic [2:0] pst_r;
  logic clk_on_r;
  logic phy_on_r;
  logic rwake_r;
  logic drop_r;
  // =========================================================
  // wake source gating
  // =========================================================
  logic armed;
  logic pend;
  logic lan_hit;
  logic ed_hit;
  logic resume_start;
  logic [`SWPSC_NPIN-1:0] pin_src;
  logic any_reset;
  assign armed = state_r == swpsc_pkg::SWPSC_SUSPENDED;
  assign any_reset = usb_reset_i || !rstn_s; // see RQ6
  // pin 7 is masked when link-up select is on; link up then wakes and sets flag 7 in levels 0 and 3 only
  always_comb begin
    pin_src = pin_s;
    pin_src[`SWPSC_LINK_PIN] = link_sel_r ? 1'b0
      : pin_s[`SWPSC_LINK_PIN];
  end
  swpsc_wake_gate u_gate (
    .clk_i(clk_i),
    .rst_i(rst_i || any_reset),
    .armed_i(armed),
    .level_i(level_r),
    .lan_wake_i(lan_wake_i),
    .good_frame_i(good_frame_i),
    .energy_i(energy_detect_i),
    .link_up_i(link_up_i && link_sel_r),
    .pin_any_i(|pin_src),
    .lan_en_i(lwe_r),
    .frame_lan_en_i(|wfcs_r),
    .resume_start_i(resume_start),
    .pend_o(pend),
    .lan_hit_o(lan_hit),
    .ed_hit_o(ed_hit)
  );
  // =========================================================
  // power state machine
  // =========================================================
  logic was_uncfg_r;
  logic was_uncfg_nxt;
  always_comb begin
    state_nxt = state_r;
    level_nxt = level_r;
    was_uncfg_nxt = was_uncfg_r;
    resume_start = 1'b0;
    if (!vbus_s) begin
      state_nxt = swpsc_pkg::SWPSC_UNPOWERED; // see RQ20
    end else if (any_reset) begin
      state_nxt = swpsc_pkg::SWPSC_NORM_UNCFG; // see RQ6
    end else begin
      unique case (state_r)
        swpsc_pkg::SWPSC_UNPOWERED: begin
          state_nxt = swpsc_pkg::SWPSC_NORM_UNCFG; // see RQ20
        end
        swpsc_pkg::SWPSC_NORM_UNCFG: begin
          if (usb_suspend_i) begin
            state_nxt = swpsc_pkg::SWPSC_SUSPENDED;
            level_nxt = `SWPSC_MODE_S2; // see RQ4
            was_uncfg_nxt = 1'b1;
          end else if (usb_configured_i) begin
            state_nxt = swpsc_pkg::SWPSC_NORM_CFG; // see RQ21
          end
        end
        swpsc_pkg::SWPSC_NORM_CFG: begin
          if (usb_deconfigured_i) begin
            state_nxt = swpsc_pkg::SWPSC_NORM_UNCFG; // see RQ21
          end else if (usb_suspend_i) begin
            state_nxt = swpsc_pkg::SWPSC_SUSPENDED;
            level_nxt = mode_r; // see RQ2 see RQ7
            was_uncfg_nxt = 1'b0;
          end
        end
        swpsc_pkg::SWPSC_SUSPENDED: begin
          // host resume in any level, or a permitted held wake
          if (usb_resume_i || pend) begin
            resume_start = 1'b1; // see RQ3 see RQ19 see RQ17
            state_nxt = was_uncfg_r ? swpsc_pkg::SWPSC_NORM_UNCFG
              : swpsc_pkg::SWPSC_NORM_CFG; // see RQ4 see RQ1
          end
        end
        default: begin
          state_nxt = swpsc_pkg::SWPSC_NORM_UNCFG;
        end
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= swpsc_pkg::SWPSC_UNPOWERED;
      level_r <= `SWPSC_MODE_DEF;
      was_uncfg_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      level_r <= level_nxt;
      was_uncfg_r <= was_uncfg_nxt;
    end
  end
  // =========================================================
  // software registers and status
  // =========================================================
  logic wb_req;
  logic wr_pm;
  logic wr_is;
  logic wr_pw;
  logic wr_wf;
  logic normal_nxt;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_pm = wb_req && wb_we_i && wb_adr_i == `SWPSC_PMCTL_ADDR;
  assign wr_is = wb_req && wb_we_i && wb_adr_i == `SWPSC_ISTS_ADDR;
  assign wr_pw = wb_req && wb_we_i && wb_adr_i == `SWPSC_PWAKE_ADDR;
  assign wr_wf = wb_req && wb_we_i && wb_adr_i == `SWPSC_WFCS_ADDR;
  assign normal_nxt = state_nxt == swpsc_pkg::SWPSC_NORM_UNCFG
    || state_nxt == swpsc_pkg::SWPSC_NORM_CFG;
  always_comb begin
    mode_nxt = mode_r;
    lwe_nxt = lwe_r;
    wakeup_status_field_nxt = wakeup_status_field_r;
    pflag_nxt = pflag_r;
    link_sel_nxt = link_sel_r;
    wfcs_nxt = wfcs_r;
    // byte 0 writes mode and enable; status clears are write-one
    if (wr_pm && wb_sel_i[0]) begin
      mode_nxt = wb_dat_i[`SWPSC_MODE_LO +: 2]; // see RQ2
      lwe_nxt = wb_dat_i[`SWPSC_LWE_BIT];
      wakeup_status_field_nxt = wakeup_status_field_r & ~wb_dat_i[`SWPSC_WAKEUP_STATUS_FIELD_LO +: 2];
    end
    if (wr_is && wb_sel_i[0]) begin
      pflag_nxt[7:0] = pflag_r[7:0] & ~wb_dat_i[7:0];
    end
    if (wr_is && wb_sel_i[1]) begin
      pflag_nxt[`SWPSC_NPIN-1:8] = pflag_r[`SWPSC_NPIN-1:8]
        & ~wb_dat_i[`SWPSC_NPIN-1:8];
    end
    if (wr_pw && wb_sel_i[0]) begin
      link_sel_nxt = wb_dat_i[0]; // see RQ18
    end
    if (wr_wf && wb_sel_i[0]) begin
      wfcs_nxt = wb_dat_i[`SWPSC_WFCS_W-1:0]; // see RQ15
    end
    if (usb_deconfigured_i && state_r == swpsc_pkg::SWPSC_NORM_CFG) begin
      mode_nxt = `SWPSC_MODE_DEF; // see RQ5
    end
    // hardware sets win over software clears
    if (lan_hit) begin
      wakeup_status_field_nxt[`SWPSC_WAKEUP_STATUS_FIELD_LAN] = 1'b1; // see RQ14
    end
    if (ed_hit) begin
      wakeup_status_field_nxt[`SWPSC_WAKEUP_STATUS_FIELD_ED] = 1'b1;
    end
    if (armed) begin
      pflag_nxt = pflag_nxt | pin_src; // see RQ16
      if (link_sel_r && link_up_i && (level_r == `SWPSC_MODE_S0
          || level_r == `SWPSC_MODE_S3)) begin
        pflag_nxt[`SWPSC_LINK_PIN] = 1'b1; // see RQ18
      end
    end
    ready_nxt = normal_nxt; // see RQ1
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || any_reset) begin
      mode_r <= `SWPSC_MODE_DEF; // see RQ7
      lwe_r <= 1'b0;
      wakeup_status_field_r <= 2'h0;
      pflag_r <= '0;
      link_sel_r <= 1'b0;
      wfcs_r <= '0;
      ready_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      lwe_r <= lwe_nxt;
      wakeup_status_field_r <= wakeup_status_field_nxt;
      pflag_r <= pflag_nxt;
      link_sel_r <= link_sel_nxt;
      wfcs_r <= wfcs_nxt;
      ready_r <= ready_nxt;
    end
  end
  // =========================================================
  // wishbone slave: ack one cycle after request, unmapped reads zero
  // =========================================================
  always_comb begin
    ack_nxt = wb_req;
    rdat_nxt = 32'h0000_0000;
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `SWPSC_PMCTL_ADDR: begin
          rdat_nxt[`SWPSC_RDY_BIT] = ready_r;
          rdat_nxt[`SWPSC_LWE_BIT] = lwe_r;
          rdat_nxt[`SWPSC_MODE_LO +: 2] = mode_r;
          rdat_nxt[`SWPSC_WAKEUP_STATUS_FIELD_LO +: 2] = wakeup_status_field_r;
          rdat_nxt[`SWPSC_STATE_LO +: 3] = state_r;
          rdat_nxt[`SWPSC_CFG_BIT] = !was_uncfg_r;
        end
        `SWPSC_ISTS_ADDR: begin
          rdat_nxt[`SWPSC_NPIN-1:0] = pflag_r;
        end
        `SWPSC_PWAKE_ADDR: begin
          rdat_nxt[0] = link_sel_r;
        end
        `SWPSC_WFCS_ADDR: begin
          rdat_nxt[`SWPSC_WFCS_W-1:0] = wfcs_r;
        end
        default: begin
          rdat_nxt = 32'h0000_0000;
        end
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end
  // =========================================================
  // registered outputs
  // =========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pst_r <= 3'h0;
      clk_on_r <= 1'b0;
      phy_on_r <= 1'b0;
      rwake_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      pst_r <= state_nxt;
      // level 3 keeps every clock; levels 0..2 stop them
      clk_on_r <= normal_nxt || (state_nxt == swpsc_pkg::SWPSC_SUSPENDED
        && level_nxt == `SWPSC_MODE_S3); // see RQ12
      phy_on_r <= normal_nxt || (state_nxt == swpsc_pkg::SWPSC_SUSPENDED
        && level_nxt != `SWPSC_MODE_S2); // see RQ11
      rwake_r <= resume_start && !usb_resume_i;
      drop_r <= armed && level_r == `SWPSC_MODE_S3
        && (|wfcs_r); // see RQ15
    end
  end
  assign wb_dat_o = rdat_r;
  assign wb_ack_o = ack_r;
  assign power_state_o = pst_r;
  assign clocks_on_o = clk_on_r;
  assign phy_power_o = phy_on_r;
  assign remote_wake_o = rwake_r;
  assign drop_frames_o = drop_r;
  assign ready_o = ready_r;
  // =========================================================
  // checks
  // =========================================================
  a_resume_ready: assert property (@(posedge clk_i) disable iff (rst_i)
    (armed && usb_resume_i && vbus_s && !any_reset) |=> ready_r)
    // see RQ1 see RQ19
    else $error("ready not set after host resume");
  a_uncfg_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == swpsc_pkg::SWPSC_NORM_UNCFG && usb_suspend_i && vbus_s
      && !any_reset) |=> level_r == `SWPSC_MODE_S2) // see RQ4
    else $error("unconfigured suspend not in level 2");
  a_deconf_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == swpsc_pkg::SWPSC_NORM_CFG && usb_deconfigured_i)
      |=> mode_r == `SWPSC_MODE_DEF) // see RQ5
    else $error("mode field not reset on deconfigure");
  a_reset_state: assert property (@(posedge clk_i) disable iff (rst_i)
    (usb_reset_i && vbus_s) |=> state_r == swpsc_pkg::SWPSC_NORM_UNCFG)
    // see RQ6
    else $error("reset did not give unconfigured state");
  a_vbus_loss: assert property (@(posedge clk_i) disable iff (rst_i)
    !vbus_s |=> state_r == swpsc_pkg::SWPSC_UNPOWERED) // see RQ20
    else $error("bus power loss not honoured");
  a_clk_level3: assert property (@(posedge clk_i) disable iff (rst_i)
    (armed && level_r == `SWPSC_MODE_S3) |-> clk_on_r) // see RQ12
    else $error("clocks stopped in level 3");
  a_pin_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (armed && pin_src[0] && !any_reset) |=> pflag_r[0]) // see RQ16
    else $error("pin flag not set");
  a_l2_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    (armed && level_r == `SWPSC_MODE_S2 && !pend && !usb_resume_i)
      |=> state_r != swpsc_pkg::SWPSC_NORM_CFG) // see RQ10
    else $error("level 2 left without permitted wake");
  c_resume: cover property (@(posedge clk_i) armed && usb_resume_i);
  c_pin_wake: cover property (@(posedge clk_i) armed && pend);
  c_level3: cover property (@(posedge clk_i)
    armed && level_r == `SWPSC_MODE_S3);
  c_unpowered: cover property (@(posedge clk_i)
    state_r == swpsc_pkg::SWPSC_UNPOWERED ##1 ready_r);
endmodule
`default_nettype wire

// file: rtl/swpsc_defs.svh
// Purpose: named constants for the suspend/wake power state controller
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes: definitions only
`ifndef SWPSC_DEFS_SVH
`define SWPSC_DEFS_SVH
// register byte offsets
`define SWPSC_PMCTL_ADDR 8'h00
`define SWPSC_ISTS_ADDR 8'h04
`define SWPSC_PWAKE_ADDR 8'h08
`define SWPSC_WFCS_ADDR 8'h0C
`define SWPSC_ADDR_W 8
// power_mgmt_control fields
`define SWPSC_RDY_BIT 0
`define SWPSC_LWE_BIT 1
`define SWPSC_MODE_LO 2
`define SWPSC_WAKEUP_STATUS_FIELD_LO 4
`define SWPSC_STATE_LO 8
`define SWPSC_CFG_BIT 12
// wakeup_status_field bits
`define SWPSC_WAKEUP_STATUS_FIELD_ED 0
`define SWPSC_WAKEUP_STATUS_FIELD_LAN 1
// wake frame control: lan wake event enables
`define SWPSC_WFCS_W 5
// pin count and link up pin
`define SWPSC_NPIN 11
`define SWPSC_LINK_PIN 7
// suspend codes
`define SWPSC_MODE_DEF 2'h2
`define SWPSC_MODE_S0 2'h0
`define SWPSC_MODE_S1 2'h1
`define SWPSC_MODE_S2 2'h2
`define SWPSC_MODE_S3 2'h3
`endif

// file: rtl/swpsc_pkg.sv
// Purpose: types of the suspend/wake power state controller
// Assumes: nothing
// Notes: state codes are also visible in the control register
package swpsc_pkg;
  typedef enum logic [2:0] {
    SWPSC_UNPOWERED = 3'h0,
    SWPSC_NORM_UNCFG = 3'h1,
    SWPSC_NORM_CFG = 3'h2,
    SWPSC_SUSPENDED = 3'h3
  } swpsc_state_t;
endpackage

// file: rtl/swpsc_sync.sv
// Purpose: two flip-flop synchroniser for a bundle of pin levels
// Assumes: inputs come from outside the clock domain
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module swpsc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  // two register stages, cleared by reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule
`default_nettype wire

// file: rtl/swpsc_wake_gate.sv
// Purpose: masks wake sources by suspend level and holds a permitted one
// Assumes: sources are synchronised pulses or levels on clk_i
// Notes: held request clears when the controller starts the resume
`timescale 1ns/10ps
`default_nettype none
module swpsc_wake_gate (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic armed_i,
  input wire logic [1:0] level_i,
  input wire logic lan_wake_i,
  input wire logic good_frame_i,
  input wire logic energy_i,
  input wire logic link_up_i,
  input wire logic pin_any_i,
  input wire logic lan_en_i,
  input wire logic frame_lan_en_i,
  input wire logic resume_start_i,
  output logic pend_o,
  output logic lan_hit_o,
  output logic ed_hit_o
);
  logic pend_r;
  logic pend_nxt;
  logic lan_ok;
  logic ed_ok;
  logic link_ok;
  logic gf_ok;
  logic hit;
  // level table: which sources may wake
  always_comb begin
    lan_ok = armed_i && level_i == `SWPSC_MODE_S0 && lan_wake_i
      && lan_en_i; // see RQ8
    ed_ok = armed_i && level_i == `SWPSC_MODE_S1 && energy_i; // see RQ9
    link_ok = armed_i && (level_i == `SWPSC_MODE_S0
      || level_i == `SWPSC_MODE_S3) && link_up_i; // see RQ8 see RQ13
    // good frames wake only in level 3 with no lan event enabled
    gf_ok = armed_i && level_i == `SWPSC_MODE_S3 && good_frame_i
      && !frame_lan_en_i; // see RQ13 see RQ15
    hit = lan_ok || ed_ok || link_ok || gf_ok
      || (armed_i && pin_any_i); // see RQ10
  end
  // pending request: set wins over the resume clear; leaving suspend
  // drops a request set in the resume cycle so it cannot linger
  always_comb begin
    pend_nxt = pend_r;
    if (resume_start_i || !armed_i) begin
      pend_nxt = 1'b0;
    end
    if (hit) begin
      pend_nxt = 1'b1; // see RQ22
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
    end
  end
  assign pend_o = pend_r;
  assign lan_hit_o = lan_ok || gf_ok; // see RQ14
  assign ed_hit_o = ed_ok;
  a_mask_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (!armed_i && !pend_r) |=> !pend_r) // see RQ22
    else $error("wake pending without being armed");
  a_gf_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (good_frame_i && level_i != `SWPSC_MODE_S3 && !pend_r && !lan_wake_i
      && !energy_i && !link_up_i && !pin_any_i) |=> !pend_r) // see RQ13
    else $error("good frame wake outside level 3");
endmodule
`default_nettype wire

// file: sim/swpsc_host_model.sv
// Purpose: usb host and driver model for the power state controller
// Assumes: classic Wishbone master, usb events on clk_i
// Notes: released bus lines except wb_we_o show the inverse of their last value
`timescale 1ns/10ps
`default_nettype none
module swpsc_host_model (
  input wire logic clk_i,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  output logic [4:0] usb_o,
  output logic tmo_o
);
  // ===========================================
  // idle lines at time zero
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
    usb_o = 5'h00;
    tmo_o = 1'b0;
  end
  // one classic cycle, held until ack is sampled at an edge
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'hF;
    wb_dat_o <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_i !== 1'b1 && n < 20);
    if (n >= 20) tmo_o <= 1'b1;
    rd = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_adr_o <= ~adr;  // released lines do not keep the last value
    wb_sel_o <= 4'h0;
    wb_dat_o <= ~wd;
  endtask
  // one-cycle usb event: 0 suspend 1 resume 2 reset 3 config 4 deconfig
  task automatic usb_event(input int idx);
    @(posedge clk_i);
    usb_o[idx] <= 1'b1;
    @(posedge clk_i);
    usb_o[idx] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Purpose: self-checking bench of the power state controller
// Assumes: 40 MHz clock, bus power present unless a test drops it
// Notes: rows give each suspend level and the sources that wake it
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin_reset_n_i = 1'b1;
  logic bus_power_detect_i = 1'b1;
  logic [3:0] wk = 4'h0;  // lan, good frame, energy, link up
  logic [10:0] pin_wake_i = 11'h000;
  wire logic cyc, stb, we, ack, tmo, clk_on, phy_on, rwake, drop, rdy;
  wire logic [7:0] adr;
  wire logic [31:0] wdat, rdat;
  wire logic [4:0] usb;
  wire logic [3:0] sel;
  wire logic [2:0] pst;
  int errors = 0;
  int samples_checked = 0;
  int rw_cnt = 0;
  // level code beside the sources that wake it: resume,lan,good,ed,link,pin
  logic [7:0] rows [4] = '{8'h33, 8'h69, 8'hA1, 8'hF5};
  // ===========================================
  always #12.5 clk_i = ~clk_i;
  // counts remote wake pulses seen at clock edges
  always @(posedge clk_i) begin
    if (rwake === 1'b1) rw_cnt <= rw_cnt + 1;
  end
  swpsc_host_model host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat),
    .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
    .wb_sel_o(sel),
    .wb_dat_o(wdat), .usb_o(usb), .tmo_o(tmo));
  swpsc_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i),
    .pin_reset_n_i(pin_reset_n_i), .usb_reset_i(usb[2]),
    .usb_suspend_i(usb[0]), .usb_resume_i(usb[1]),
    .usb_configured_i(usb[3]), .usb_deconfigured_i(usb[4]),
    .bus_power_detect_i(bus_power_detect_i), .lan_wake_i(wk[0]),
    .good_frame_i(wk[1]), .energy_detect_i(wk[2]), .link_up_i(wk[3]),
    .pin_wake_i(pin_wake_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .power_state_o(pst), .clocks_on_o(clk_on),
    .phy_power_o(phy_on), .remote_wake_o(rwake),
    .drop_frames_o(drop), .ready_o(rdy));
  // ===========================================
  // compare tasks: register words and output pins
  task automatic chk_word(input logic [31:0] e, input logic [31:0] a);
    samples_checked++;
    if (a !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask
  task automatic chk_out(input logic [2:0] e, input logic [2:0] a);
    samples_checked++;
    if (a !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    host.xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    host.xfer(1'b0, a, 32'h0, x);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    rd(a, x);
    chk_word(e, x);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // bounded wait for a power state, then compare it
  task automatic go(input logic [2:0] s);
    int n;
    n = 0;
    while (pst !== s && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk_out(s, pst);
  endtask
  // raise one wake source: 0 host resume, 1..4 wk, 5 pin 0
  task automatic fire(input int sr);
    if (sr == 0) begin
      host.usb_event(1);
    end else begin
      @(posedge clk_i);
      if (sr == 5) pin_wake_i[0] <= 1'b1;
      else wk[sr-1] <= 1'b1;
      idle(4);
      pin_wake_i[0] <= 1'b0;
      wk <= 4'h0;
    end
  endtask
  task automatic results();
    if (tmo === 1'b1) errors++;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ===========================================
  // main sequence
  initial begin : main
    logic [31:0] x;
    logic [1:0] lv;
    logic [1:0] st;
    int rw0;
    idle(4);
    rst_i <= 1'b0;
    go(3'h1);
    rd_chk(8'h00, 32'h109);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h10, 32'h0); // unmapped place reads zero
    wr(8'h08, 32'h1);
    rd_chk(8'h08, 32'h1);
    host.usb_event(3);
    go(3'h2);
    $display("test reset_and_map done");
    for (int r = 0; r < 4; r++) begin
      for (int sr = 0; sr < 6; sr++) begin
        lv = rows[r][7:6];
        wr(8'h0C, 32'h0);
        wr(8'h04, 32'h7FF);
        wr(8'h00, {26'h0, 2'h3, lv, 2'h2});
        host.usb_event(0);
        go(3'h3);
        chk_out({2'h0, lv == 2'h3}, {2'h0, clk_on});
        chk_out({2'h0, lv != 2'h2}, {2'h0, phy_on});
        rw0 = rw_cnt;
        fire(sr);
        if (rows[r][sr]) begin
          go(3'h2);
        end else begin
          idle(12);
          chk_out(3'h3, pst);
          host.usb_event(1);
          go(3'h2);
        end
        chk_out(3'h1, {2'h0, rdy});
        st[1] = (lv == 2'h0 && sr == 1) || (lv == 2'h3 && sr == 2);
        st[0] = (lv == 2'h1 && sr == 3);
        rd(8'h00, x);
        chk_word({30'h0, st}, {30'h0, x[5:4]});
        chk_out({2'h0, rows[r][sr] && sr != 0}, {2'h0, rw_cnt != rw0});
        if (sr == 5) rd_chk(8'h04, 32'h1);
        else if (sr == 4 && lv[0] == lv[1]) rd_chk(8'h04, 32'h80);
        else rd_chk(8'h04, 32'h0);
      end
    end
    $display("test level_table done");
    wr(8'h04, 32'h7FF);
    wr(8'h0C, 32'h1);
    wr(8'h00, 32'h3E);
    host.usb_event(0);
    go(3'h3);
    idle(1);
    chk_out(3'h1, {2'h0, drop});
    fire(2);
    idle(12);
    chk_out(3'h3, pst);
    host.usb_event(2);
    go(3'h1);
    rd_chk(8'h0C, 32'h0);
    $display("test level3_drop_usb_reset done");
    host.usb_event(3);
    go(3'h2);
    wr(8'h00, 32'h2);
    host.usb_event(4);
    go(3'h1);
    rd(8'h00, x);
    chk_word(32'h2, {30'h0, x[3:2]});
    wr(8'h00, 32'h2);
    host.usb_event(0);
    go(3'h3);
    chk_out(3'h0, {2'h0, phy_on});
    fire(1);
    idle(12);
    chk_out(3'h3, pst);
    fire(0);
    go(3'h1);
    $display("test unconfigured_suspend done");
    pin_wake_i <= 11'h7FE;
    idle(4);
    host.usb_event(0);
    idle(15);
    chk_out(3'h1, pst);
    pin_wake_i <= 11'h000;
    rd_chk(8'h04, 32'h7FE);
    wr(8'h04, 32'h7FF);
    host.usb_event(0);
    go(3'h3);
    pin_reset_n_i <= 1'b0;
    idle(4);
    pin_reset_n_i <= 1'b1;
    go(3'h1);
    $display("test pending_and_pin_reset done");
    bus_power_detect_i <= 1'b0;
    go(3'h0);
    host.usb_event(1);
    idle(12);
    chk_out(3'h0, pst);
    chk_out(3'h0, {2'h0, rdy});
    bus_power_detect_i <= 1'b1;
    go(3'h1);
    $display("test bus_power done");
    results();
  end
  // hang guard, far beyond the expected thousand or so cycles
  initial begin : watchdog
    idle(30000);
    errors++;
    results();
  end
endmodule
`default_nettype wire
